// ===== rtl/vxr_ext_regs.sv
`timescale 1ns/1ns
// How it works
// R1: misc_output_ctrl written at 3C2, read at 3CC
// R2: Reading 3C2 returns input_status_zero
// R3: Bits 7/6 set vsync/hsync polarity, 1=low
// R4: Those bits act only in enhanced mode
// R5: Bit 5 is address lsb in odd/even
// R6: Bit 4 disables external video drivers
// R7: Bits 3-2 choose clock and switch
// R8: Software changes clock only under sequencer reset
// R9: Clock bits mirrored; port write clears msb
// R10: Bit 1 gates processor display memory access
// R11: Bit 0 moves CRTC/status ports 3Bx/3Dx
// R12: Feature control written 3?A, read 3CA
// R13: Feature control bit 7 drives feature pins
// R14: Feature control bits 1-0 drive outputs
// R15: Status zero bit 7 follows IRQ2 line
// R16: Vsync leading edge raises interrupt when enabled
// R17: Status zero bits 6-5 show feature pins
// R18: Bit 4 senses switch chosen by clock select
// R19: Display status bit 7 is not-vretrace
// R20: Bit 3 vretrace, or pixel in monochrome
// R21: Bits 5-4 carry two diagnostic signals
// R22: Reset clears all but driver-disable bit
// R23: Protection bits 0/3 block write groups
// R24: Display status bit 0 is inverse enable
// R25: Unused bits read zero, ignore writes; the code stores unused feature control bit 3 and reads it back at 3CA
module vxr_ext_regs
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire vxr_pkg::vxr_io_s io_i,
  output logic [7:0] io_rdata_o,
  output logic io_rdata_valid_o,
  output logic crtc_sel_o,
  input wire logic [7:0] write_protect_ctrl_i,
  input wire vxr_pkg::vxr_mode_e adapter_mode_i,
  input wire logic tc_vsync_neg_i,
  input wire logic tc_hsync_neg_i,
  input wire logic memory_mode_reg_oddeven_i,
  input wire logic vint_disable_i,
  input wire logic vint_clear_n_i,
  input wire logic ext_clk_wr_i,
  input wire logic [2:0] ext_clk_wdata_i,
  input wire vxr_pkg::vxr_video_s video_i,
  input wire logic lpen_switch_i,
  input wire logic lpen_ff_i,
  input wire logic irq2_bus_i,
  input wire logic [7:0] cfg_switch_open_i,
  input wire logic [1:0] input_status_zero_code_in_i,
  output logic [1:0] input_status_zero_code_out_o,
  output logic [1:0] input_status_zero_code_oe_n_o,
  output logic feature_out_zero_o,
  output logic feature_out_one_o,
  output logic ext_video_drv_disable_o,
  output logic page_addr_lsb_o,
  output logic page_addr_lsb_en_o,
  output logic mem_access_en_o,
  output logic colour_io_o,
  output logic [2:0] clock_source_select_o,
  output logic hsync_o,
  output logic vsync_o,
  output logic crt_irq_o
);
  import vxr_pkg::*;

  // Switch k+1 sits at bit k; values 0-3 walk switches 4 down to 1
  function automatic logic [2:0] switch_index(input logic [2:0] sel);
    logic [2:0] idx;
    idx = sel;
    if (!sel[2])
      idx = 3'h3 - sel;
    return idx;
  endfunction

  function automatic logic port_is(input logic [9:0] a, input logic [9:0] port);
    return a == port;
  endfunction

  logic [7:0] moc_r;
  logic [7:0] moc_nxt;
  logic [7:0] fcc_r;
  logic [7:0] fcc_nxt;
  logic clk_msb_r;
  logic clk_msb_nxt;
  logic [7:0] moc_wmask;
  logic moc_clk_written;
  logic [9:0] dst_port;
  logic wr_moc;
  logic wr_fcc;
  logic rd_moc;
  logic rd_isz;
  logic rd_fcc;
  logic rd_dst;
  logic rd_hit;
  logic [7:0] isz_val;
  logic [7:0] dst_val;
  logic [7:0] rdata_nxt;
  logic [1:0] input_status_zero_pin_level;
  logic [1:0] input_status_zero_out_r;
  logic [1:0] input_status_zero_oe_n_r;
  logic [2:0] clk_sel;

  // Port decode
  assign dst_port = moc_r[MOC_IO_COLOUR] ? ADDR_DST_COLOUR : ADDR_DST_MONO; // [R11] [R12]
  assign wr_moc = io_i.wr && port_is(io_i.addr, ADDR_MOC_WR); // [R1]
  assign wr_fcc = io_i.wr && port_is(io_i.addr, dst_port); // [R12]
  assign rd_moc = io_i.rd && port_is(io_i.addr, ADDR_MOC_RD); // [R1]
  assign rd_isz = io_i.rd && port_is(io_i.addr, ADDR_ISZ_RD); // [R2]
  assign rd_fcc = io_i.rd && port_is(io_i.addr, ADDR_FCC_RD); // [R12]
  assign rd_dst = io_i.rd && port_is(io_i.addr, dst_port); // [R12]
  assign rd_hit = rd_moc || rd_isz || rd_fcc || rd_dst;

  // Only the selected CRTC block answers; the other one is left to other cards
  always_comb
  begin
    if (moc_r[MOC_IO_COLOUR])
      crtc_sel_o = (io_i.rd || io_i.wr) && (io_i.addr[9:4] == CRTC_BLOCK_COLOUR); // [R11]
    else
      crtc_sel_o = (io_i.rd || io_i.wr) && (io_i.addr[9:4] == CRTC_BLOCK_MONO); // [R11]
  end

  // Write protection by groups
  always_comb
  begin
    moc_wmask = 8'hFF;
    if (write_protect_ctrl_i[WRC_GROUP_A])
      moc_wmask = moc_wmask & ~MOC_GROUP_A; // [R23]
    if (write_protect_ctrl_i[WRC_GROUP_B])
      moc_wmask = moc_wmask & ~MOC_GROUP_B; // [R23]
  end

  assign moc_clk_written = wr_moc && !write_protect_ctrl_i[WRC_GROUP_A];

  always_comb
  begin
    moc_nxt = moc_r;
    if (wr_moc)
      moc_nxt = (moc_r & ~moc_wmask) | (io_i.wdata & moc_wmask); // [R1] [R23]
    if (ext_clk_wr_i)
    begin
      moc_nxt[MOC_CLK_HI] = ext_clk_wdata_i[1]; // [R9]
      moc_nxt[MOC_CLK_LO] = ext_clk_wdata_i[0]; // [R9]
    end
  end

  // Clock select msb lives only in the extension view of the field
  always_comb
  begin
    clk_msb_nxt = clk_msb_r;
    if (moc_clk_written)
      clk_msb_nxt = 1'b0; // [R9]
    if (ext_clk_wr_i)
      clk_msb_nxt = ext_clk_wdata_i[2]; // [R9]
  end

  always_comb
  begin
    fcc_nxt = fcc_r;
    if (wr_fcc && !write_protect_ctrl_i[WRC_GROUP_B])
      fcc_nxt = io_i.wdata & FCC_STORED; // [R12] [R25]
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      moc_r <= MOC_RESET; // [R22]
    else
      moc_r <= moc_nxt;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      clk_msb_r <= 1'b0;
    else
      clk_msb_r <= clk_msb_nxt;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      fcc_r <= FCC_RESET;
    else
      fcc_r <= fcc_nxt;
  end

  // Clock source: changing it outside sequencer reset glitches the dot clock
  assign clk_sel = {clk_msb_r, moc_r[MOC_CLK_HI], moc_r[MOC_CLK_LO]}; // [R7] [R8]
  assign clock_source_select_o = clk_sel; // [R7]

  // Register-driven control outputs
  assign ext_video_drv_disable_o = moc_r[MOC_VDRV_DIS]; // [R6]
  assign page_addr_lsb_o = moc_r[MOC_PAGE]; // [R5]
  assign page_addr_lsb_en_o = memory_mode_reg_oddeven_i; // [R5]
  assign mem_access_en_o = moc_r[MOC_RAM_EN]; // [R10]
  assign colour_io_o = moc_r[MOC_IO_COLOUR]; // [R11]
  assign feature_out_zero_o = fcc_r[FCC_OUT0]; // [R14]
  assign feature_out_one_o = fcc_r[FCC_OUT1]; // [R14]

  // Feature code pins turn into video bits 7 and 6 when 8-bit video is on
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      input_status_zero_out_r <= 2'b00;
      input_status_zero_oe_n_r <= 2'b11;
    end
    else
    begin
      input_status_zero_out_r <= {video_i.video_hi[0], video_i.video_hi[1]}; // [R13]
      input_status_zero_oe_n_r <= {2{~fcc_r[FCC_VIDEO8]}}; // [R13]
    end
  end

  assign input_status_zero_code_out_o = input_status_zero_out_r;
  assign input_status_zero_code_oe_n_o = input_status_zero_oe_n_r;

  // Read back what the pins carry, whoever drives them
  always_comb
  begin
    if (!input_status_zero_oe_n_r[0])
      input_status_zero_pin_level = input_status_zero_out_r; // [R17]
    else
      input_status_zero_pin_level = input_status_zero_code_in_i; // [R17]
  end

  always_comb
  begin
    isz_val = 8'h00; // [R25]
    isz_val[ISZ_IRQ] = irq2_bus_i; // [R15]
    isz_val[ISZ_FEATURE_CODE_IN_ONE] = input_status_zero_pin_level[1]; // [R17]
    isz_val[ISZ_FEATURE_CODE_IN_ZERO] = input_status_zero_pin_level[0]; // [R17]
    isz_val[ISZ_SWITCH] = cfg_switch_open_i[switch_index(clk_sel)]; // [R18]
  end

  always_comb
  begin
    dst_val = 8'h00; // [R25]
    dst_val[DST_NOT_VRT] = ~video_i.vsync; // [R19]
    dst_val[DST_DIAG1] = video_i.diag[1]; // [R21]
    dst_val[DST_DIAG0] = video_i.diag[0]; // [R21]
    if (adapter_mode_i == MODE_MGA)
      dst_val[DST_VRT_PIX] = video_i.pixel; // [R20]
    else
      dst_val[DST_VRT_PIX] = video_i.vsync; // [R20]
    dst_val[DST_LPEN_SW] = lpen_switch_i;
    dst_val[DST_LPEN_FF] = lpen_ff_i;
    dst_val[DST_NOT_DE] = ~video_i.display_active; // [R24]
  end

  always_comb
  begin
    rdata_nxt = RDATA_RESET;
    if (rd_moc)
      rdata_nxt = moc_r; // [R1]
    else if (rd_isz)
      rdata_nxt = isz_val; // [R2]
    else if (rd_fcc)
      rdata_nxt = fcc_r; // [R12]
    else if (rd_dst)
      rdata_nxt = dst_val; // [R12]
  end

  // Read data is held until the next read so a slow host can sample it
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      io_rdata_o <= RDATA_RESET;
    else if (rd_hit)
      io_rdata_o <= rdata_nxt;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      io_rdata_valid_o <= 1'b0;
    else
      io_rdata_valid_o <= rd_hit;
  end

  vxr_sync_out u_sync_out
  (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .mode_i(adapter_mode_i),
    .moc_vpol_i(moc_r[MOC_VPOL]),
    .moc_hpol_i(moc_r[MOC_HPOL]),
    .tc_vsync_neg_i(tc_vsync_neg_i),
    .tc_hsync_neg_i(tc_hsync_neg_i),
    .hsync_raw_i(video_i.hsync),
    .vsync_raw_i(video_i.vsync),
    .vint_disable_i(vint_disable_i),
    .vint_clear_n_i(vint_clear_n_i),
    .hsync_o(hsync_o),
    .vsync_o(vsync_o),
    .crt_irq_o(crt_irq_o)
  );

endmodule // vxr_ext_regs

// ===== include/vxr_pkg.sv
package vxr_pkg;

  localparam int unsigned IO_AW = 10;

  // Host port decode
  localparam logic [9:0] ADDR_MOC_WR = 10'h3C2;
  localparam logic [9:0] ADDR_MOC_RD = 10'h3CC;
  localparam logic [9:0] ADDR_ISZ_RD = 10'h3C2;
  localparam logic [9:0] ADDR_FCC_RD = 10'h3CA;
  localparam logic [9:0] ADDR_DST_MONO = 10'h3BA;
  localparam logic [9:0] ADDR_DST_COLOUR = 10'h3DA;
  localparam logic [5:0] CRTC_BLOCK_MONO = 6'h3B;
  localparam logic [5:0] CRTC_BLOCK_COLOUR = 6'h3D;

  // misc_output_ctrl fields
  localparam int unsigned MOC_VPOL = 7;
  localparam int unsigned MOC_HPOL = 6;
  localparam int unsigned MOC_PAGE = 5;
  localparam int unsigned MOC_VDRV_DIS = 4;
  localparam int unsigned MOC_CLK_HI = 3;
  localparam int unsigned MOC_CLK_LO = 2;
  localparam int unsigned MOC_RAM_EN = 1;
  localparam int unsigned MOC_IO_COLOUR = 0;
  localparam logic [7:0] MOC_RESET = 8'h10;
  localparam logic [7:0] MOC_GROUP_A = 8'hCC;
  localparam logic [7:0] MOC_GROUP_B = 8'h33;
  localparam logic [7:0] MOC_CLK_FIELD = 8'h0C;

  // feature_connector_ctrl fields
  localparam int unsigned FCC_VIDEO8 = 7;
  localparam int unsigned FCC_OUT1 = 1;
  localparam int unsigned FCC_OUT0 = 0;
  localparam logic [7:0] FCC_STORED = 8'h8B;
  localparam logic [7:0] FCC_RESET = 8'h00;

  // write_protect_ctrl bits guarding the two groups
  localparam int unsigned WRC_GROUP_A = 0;
  localparam int unsigned WRC_GROUP_B = 3;

  // input_status_zero and display_status fields
  localparam int unsigned ISZ_IRQ = 7;
  localparam int unsigned ISZ_FEATURE_CODE_IN_ONE = 6;
  localparam int unsigned ISZ_FEATURE_CODE_IN_ZERO = 5;
  localparam int unsigned ISZ_SWITCH = 4;
  localparam int unsigned DST_NOT_VRT = 7;
  localparam int unsigned DST_DIAG1 = 5;
  localparam int unsigned DST_DIAG0 = 4;
  localparam int unsigned DST_VRT_PIX = 3;
  localparam int unsigned DST_LPEN_SW = 2;
  localparam int unsigned DST_LPEN_FF = 1;
  localparam int unsigned DST_NOT_DE = 0;

  localparam logic [7:0] RDATA_RESET = 8'h00;

  typedef enum logic [1:0] {
    MODE_EGA = 2'b00,
    MODE_CGA = 2'b01,
    MODE_MGA = 2'b11
  } vxr_mode_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } vxr_io_s;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic display_active;
    logic pixel;
    logic [1:0] diag;
    logic [1:0] video_hi;
  } vxr_video_s;

endpackage

// ===== rtl/vxr_sync_out.sv
`timescale 1ns/1ns
module vxr_sync_out
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire vxr_pkg::vxr_mode_e mode_i,
  input wire logic moc_vpol_i,
  input wire logic moc_hpol_i,
  input wire logic tc_vsync_neg_i,
  input wire logic tc_hsync_neg_i,
  input wire logic hsync_raw_i,
  input wire logic vsync_raw_i,
  input wire logic vint_disable_i,
  input wire logic vint_clear_n_i,
  output logic hsync_o,
  output logic vsync_o,
  output logic crt_irq_o
);
  import vxr_pkg::*;

  logic vneg;
  logic hneg;
  logic vsync_prev_r;
  logic irq_r;
  logic irq_nxt;

  always_comb
  begin
    if (mode_i == MODE_EGA)
    begin
      vneg = moc_vpol_i; // [R3] [R4]
      hneg = moc_hpol_i; // [R3] [R4]
    end
    else
    begin
      vneg = tc_vsync_neg_i; // [R4]
      hneg = tc_hsync_neg_i; // [R4]
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      hsync_o <= 1'b0;
      vsync_o <= 1'b0;
    end
    else
    begin
      hsync_o <= hsync_raw_i ^ hneg; // [R3]
      vsync_o <= vsync_raw_i ^ vneg; // [R3]
    end
  end

  // A new edge wins over a clear held in the same cycle
  always_comb
  begin
    irq_nxt = irq_r;
    if (!vint_clear_n_i)
      irq_nxt = 1'b0;
    if (vsync_raw_i && !vsync_prev_r && !vint_disable_i)
      irq_nxt = 1'b1; // [R16]
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      vsync_prev_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      vsync_prev_r <= vsync_raw_i;
      irq_r <= irq_nxt;
    end
  end

  assign crt_irq_o = irq_r;

endmodule // vxr_sync_out

// ===== tb/vxr_ext_regs_monitor.sv
`timescale 1ns/1ns
module vxr_ext_regs_monitor
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire vxr_pkg::vxr_io_s io_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic io_rdata_valid_o,
  input wire logic [7:0] write_protect_ctrl_i,
  input wire vxr_pkg::vxr_mode_e adapter_mode_i,
  input wire logic tc_vsync_neg_i,
  input wire logic vint_disable_i,
  input wire logic ext_clk_wr_i,
  input wire vxr_pkg::vxr_video_s video_i,
  input wire logic irq2_bus_i,
  input wire logic ext_video_drv_disable_o,
  input wire logic colour_io_o,
  input wire logic [2:0] clock_source_select_o,
  input wire logic vsync_o,
  input wire logic crt_irq_o
);
  import vxr_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic mw = io_i.wr && io_i.addr == ADDR_MOC_WR;
  wire logic dr = io_i.rd && io_i.addr == (colour_io_o ? ADDR_DST_COLOUR : ADDR_DST_MONO);
  AST_MOC_RD: assert property (io_i.rd && io_i.addr == ADDR_MOC_RD |=> io_rdata_valid_o)
    else $error("control read not answered");
  AST_DRV: assert property (mw && !write_protect_ctrl_i[3] |=>
    ext_video_drv_disable_o == $past(io_i.wdata[4])) else $error("driver bit wrong");
  AST_CLK: assert property (mw && !write_protect_ctrl_i[0] && !ext_clk_wr_i |=>
    clock_source_select_o == {1'b0, $past(io_i.wdata[3:2])}) else $error("clock field wrong");
  AST_ISZ: assert property (io_i.rd && io_i.addr == ADDR_ISZ_RD |=>
    io_rdata_o[7] == $past(irq2_bus_i) && io_rdata_o[3:0] == 4'h0) else $error("status zero wrong");
  AST_DST: assert property (dr |=> io_rdata_valid_o &&
    io_rdata_o[7] == !$past(video_i.vsync) && io_rdata_o[6] == 1'b0) else $error("status wrong");
  AST_POL: assert property (adapter_mode_i == MODE_CGA |=>
    vsync_o == $past(video_i.vsync ^ tc_vsync_neg_i)) else $error("sync polarity wrong");
  AST_IRQ: assert property (video_i.vsync && !$past(video_i.vsync) && !vint_disable_i |=>
    crt_irq_o) else $error("interrupt missed");
  AST_RST: assert property ($rose(rstn_i) |->
    ext_video_drv_disable_o && clock_source_select_o == 3'h0) else $error("reset state wrong");
  COV_IRQ: cover property (!crt_irq_o ##1 crt_irq_o);
  COV_PROT: cover property (mw && write_protect_ctrl_i[0]);
  COV_COL: cover property (dr && colour_io_o);
endmodule // vxr_ext_regs_monitor

bind vxr_ext_regs vxr_ext_regs_monitor u_mon (.core_clk_i, .rstn_i, .io_i, .io_rdata_o,
  .io_rdata_valid_o, .write_protect_ctrl_i, .adapter_mode_i, .tc_vsync_neg_i, .vint_disable_i,
  .ext_clk_wr_i, .video_i, .irq2_bus_i, .ext_video_drv_disable_o, .colour_io_o,
  .clock_source_select_o, .vsync_o, .crt_irq_o);

// ===== tb/vxr_host_model.sv
`timescale 1ns/1ns
module vxr_host_model
(
  input wire logic core_clk_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic io_rdata_valid_o,
  output vxr_pkg::vxr_io_s io_o
);
  import vxr_pkg::*;
  initial io_o = '{1'b0, 1'b0, 10'h3FF, 8'hFF};
  // Released lines show the inverse, so a stale address never passes as live
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    io_o = '{1'b0, 1'b1, a, d};
    @(negedge core_clk_i);
    io_o = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task rd(input logic [9:0] a, output logic v, output logic [7:0] d);
    @(negedge core_clk_i);
    io_o = '{1'b1, 1'b0, a, 8'h00};
    @(negedge core_clk_i);
    io_o = '{1'b0, 1'b0, ~a, 8'hFF};
    v = io_rdata_valid_o;
    d = io_rdata_o;
  endtask
endmodule // vxr_host_model

// ===== tb/tb_vxr_ext_regs.sv
`timescale 1ns/1ns
module tb_vxr_ext_regs;
  import vxr_pkg::*;
  logic core_clk_i = 1'b0, rstn_i = 1'b0;
  vxr_io_s io_i;
  logic [7:0] io_rdata_o, write_protect_ctrl_i = 8'h00, cfg_switch_open_i = 8'h00, rdata;
  logic io_rdata_valid_o, tc_vsync_neg_i = 0, vint_disable_i = 0, vint_clear_n_i = 1, v;
  logic tc_hsync_neg_i = 0, memory_mode_reg_oddeven_i = 0, crtc_sel_o, hsync_o, vsync_o;
  logic page_addr_lsb_o, page_addr_lsb_en_o, mem_access_en_o;
  logic [1:0] input_status_zero_code_out_o;
  logic ext_clk_wr_i = 0, lpen_switch_i = 0, lpen_ff_i = 0, irq2_bus_i = 0;
  logic feature_out_zero_o, feature_out_one_o, ext_video_drv_disable_o, colour_io_o, crt_irq_o;
  logic [2:0] ext_clk_wdata_i = 3'h0, clock_source_select_o;
  logic [1:0] input_status_zero_code_in_i = 2'b00, input_status_zero_code_oe_n_o;
  vxr_mode_e adapter_mode_i = MODE_EGA;
  vxr_mode_e ms[3] = '{MODE_EGA, MODE_CGA, MODE_MGA};
  vxr_video_s video_i = '0;
  logic [31:0] seed = 32'h0000CFF7, r;
  logic [9:0] sa;
  int misc = 'h10, fc = 0, msb = 0, n_compared = 0, fails = 0, cyc = 0;

  vxr_ext_regs u_vxr_ext_regs (.core_clk_i, .rstn_i, .io_i, .io_rdata_o, .io_rdata_valid_o,
    .crtc_sel_o, .write_protect_ctrl_i, .adapter_mode_i, .tc_vsync_neg_i,
    .tc_hsync_neg_i, .memory_mode_reg_oddeven_i, .vint_disable_i, .vint_clear_n_i,
    .ext_clk_wr_i, .ext_clk_wdata_i, .video_i, .lpen_switch_i, .lpen_ff_i, .irq2_bus_i,
    .cfg_switch_open_i, .input_status_zero_code_in_i, .input_status_zero_code_out_o, .input_status_zero_code_oe_n_o,
    .feature_out_zero_o, .feature_out_one_o, .ext_video_drv_disable_o, .page_addr_lsb_o,
    .page_addr_lsb_en_o, .mem_access_en_o, .colour_io_o, .clock_source_select_o,
    .hsync_o, .vsync_o, .crt_irq_o);
  vxr_host_model u_host (.core_clk_i, .io_rdata_o, .io_rdata_valid_o, .io_o(io_i));

  always #25 core_clk_i = ~core_clk_i;

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [7:0] isz();
    int k;
    k = msb * 4 + misc[3:2];
    if (k < 4)
      k = 3 - k;
    return {irq2_bus_i,
      (fc[7] ? {video_i.video_hi[0], video_i.video_hi[1]} : input_status_zero_code_in_i),
      cfg_switch_open_i[k], 4'h0};
  endfunction
  function logic [7:0] dst();
    return {~video_i.vsync, 1'b0, video_i.diag,
      (adapter_mode_i == MODE_MGA) ? video_i.pixel : video_i.vsync,
      lpen_switch_i, lpen_ff_i, ~video_i.display_active};
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rdx(input logic [9:0] a, input logic [7:0] exp);
    u_host.rd(a, v, rdata);
    chk({7'h0, v}, 8'h01);
    chk(rdata, exp);
  endtask
  // Status inputs are drawn fresh so stale samples cannot match by luck
  task shake();
    @(negedge core_clk_i);
    r = rnd();
    {irq2_bus_i, input_status_zero_code_in_i, cfg_switch_open_i, lpen_switch_i, lpen_ff_i} = r[12:0];
    {tc_hsync_neg_i, tc_vsync_neg_i} = r[14:13];
    video_i = r[31:24];
  endtask
  task end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      end_of_test();
    end
  end

  // Port block select is judged while a request stands
  always @(posedge core_clk_i)
    if (rstn_i && (io_i.rd || io_i.wr))
      chk({7'h0, crtc_sel_o}, {7'h0, io_i.addr[9:4] == (misc[0] ? 6'h3D : 6'h3B)});

  initial
  begin
    repeat (4) @(negedge core_clk_i);
    rstn_i = 1'b1;
    rdx(ADDR_MOC_RD, 8'h10);
    rdx(ADDR_FCC_RD, 8'h00);
    for (int i = 0; i < 24; i++)
    begin
      r = rnd();
      write_protect_ctrl_i = r[15:8] & 8'h09;
      memory_mode_reg_oddeven_i = r[16];
      if (!r[8])
      begin
        misc = (misc & 'h33) | (r[7:0] & 'hCC);
        msb = 0;
      end
      if (!r[11])
        misc = (misc & 'hCC) | (r[7:0] & 'h33);
      u_host.wr(ADDR_MOC_WR, r[7:0]);
      rdx(ADDR_MOC_RD, misc[7:0]);
      chk({page_addr_lsb_o, page_addr_lsb_en_o, mem_access_en_o, ext_video_drv_disable_o,
        colour_io_o, clock_source_select_o},
        {misc[5], r[16], misc[1], misc[4], misc[0], msb[0], misc[3:2]});
    end
    $display("misc test done");
    write_protect_ctrl_i = 8'h00;
    // Clock field writes stand for writes made while the sequencer is held in reset
    for (int s = 0; s < 8; s++)
    begin
      misc[3:2] = s[1:0];
      msb = s[2];
      u_host.wr(ADDR_MOC_WR, misc[7:0]);
      ext_clk_wr_i = 1'b1;
      ext_clk_wdata_i = s[2:0];
      @(negedge core_clk_i);
      ext_clk_wr_i = 1'b0;
      shake();
      rdx(ADDR_ISZ_RD, isz());
      chk({5'h0, clock_source_select_o}, s[7:0]);
    end
    $display("switch test done");
    for (int i = 0; i < 6; i++)
    begin
      r = rnd();
      sa = misc[0] ? ADDR_DST_COLOUR : ADDR_DST_MONO;
      u_host.wr(sa ^ 10'h060, ~r[7:0]);
      u_host.wr(sa, r[7:0]);
      fc = r[7:0] & 'h8B;
      rdx(ADDR_FCC_RD, fc[7:0]);
      chk({4'h0, input_status_zero_code_oe_n_o, feature_out_one_o, feature_out_zero_o},
        {4'h0, ~{2{fc[7]}}, fc[1:0]});
      shake();
      rdx(sa, dst());
      chk({6'h0, input_status_zero_code_out_o}, {6'h0, video_i.video_hi[0], video_i.video_hi[1]});
      rdx(ADDR_ISZ_RD, isz());
      u_host.rd(sa ^ 10'h060, v, rdata);
      chk({7'h0, v}, 8'h00);
      misc ^= 1;
      msb = 0;
      u_host.wr(ADDR_MOC_WR, misc[7:0]);
    end
    u_host.rd(10'h3C0, v, rdata);
    chk({7'h0, v}, 8'h00);
    $display("feature test done");
    sa = misc[0] ? ADDR_DST_COLOUR : ADDR_DST_MONO;
    foreach (ms[m])
    begin
      adapter_mode_i = ms[m];
      misc ^= 'hC0;
      msb = 0;
      u_host.wr(ADDR_MOC_WR, misc[7:0]);
      shake();
      rdx(sa, dst());
      chk({6'h0, hsync_o, vsync_o}, {6'h0,
        video_i.hsync ^ ((adapter_mode_i == MODE_EGA) ? misc[6] : tc_hsync_neg_i),
        video_i.vsync ^ ((adapter_mode_i == MODE_EGA) ? misc[7] : tc_vsync_neg_i)});
    end
    $display("mode test done");
    @(negedge core_clk_i);
    video_i.vsync = 1'b0;
    vint_disable_i = 1'b0;
    vint_clear_n_i = 1'b0;
    @(negedge core_clk_i);
    vint_clear_n_i = 1'b1;
    video_i.vsync = 1'b1;
    @(negedge core_clk_i);
    chk({7'h0, crt_irq_o}, 8'h01);
    vint_clear_n_i = 1'b0;
    vint_disable_i = 1'b1;
    video_i.vsync = 1'b0;
    @(negedge core_clk_i);
    vint_clear_n_i = 1'b1;
    video_i.vsync = 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk({7'h0, crt_irq_o}, 8'h00);
    $display("interrupt test done");
    end_of_test();
  end
endmodule // tb_vxr_ext_regs
